// *** pkg/touch_adc_map.vh ***
`ifndef TOUCH_ADC_MAP_VH
`define TOUCH_ADC_MAP_VH

// ----------------------------------------------------------------------
// Frame timing, counted in host shift clock cycles.
// ----------------------------------------------------------------------
`define FRAME_CLKS        5'h18
`define CMD_BITS          5'h08
`define ACQ_START_CNT     5'h05
`define ACQ_END_CNT       5'h08
`define CH_DONE_CNT       5'h03
`define BYTE_DONE_CNT     5'h07
`define CONV_BITS_HI      4'hc
`define CONV_BITS_LO      4'h8

// ----------------------------------------------------------------------
// Command byte field positions, start flag in the top bit.
// ----------------------------------------------------------------------
`define CMD_START_BIT     7
`define CMD_CH_MSB        6
`define CMD_CH_LSB        4
`define CMD_RES_BIT       3
`define CMD_REF_BIT       2
`define CMD_PD_MSB        1
`define CMD_PD_LSB        0

// ----------------------------------------------------------------------
// Channel select codes.
// ----------------------------------------------------------------------
`define CH_TEMP_BASE      3'h0
`define CH_Y_POS          3'h1
`define CH_BATTERY        3'h2
`define CH_Z1_POS         3'h3
`define CH_Z2_POS         3'h4
`define CH_X_POS          3'h5
`define CH_TEMP_91X       3'h7

// ----------------------------------------------------------------------
// Panel driver enables {x_pos, x_neg, y_pos, y_neg}.
// ----------------------------------------------------------------------
`define DRV_NONE          4'h0
`define DRV_Y_PAIR        4'h3
`define DRV_YP_XN         4'h6
`define DRV_X_PAIR        4'hc

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define RST_CHANNEL       3'h0
`define RST_PD            2'h0

`endif

// *** core/sar_register.v ***
`timescale 1ns/1ps

module sar_register #(
    parameter WIDTH = 12
) (
    // Clock and reset.
    input  wire             core_clk_i,
    input  wire             rst_i,
    // Control.
    input  wire             load_i,
    input  wire             step_i,
    input  wire             comp_i,
    // Trial code toward the capacitor array.
    output reg  [WIDTH-1:0] dac_code_o
);

    reg [WIDTH-1:0] trial_r;

    // ------------------------------------------------------------------
    // Successive approximation, one decision per step.
    // ------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            trial_r    <= {WIDTH{1'b0}};
            dac_code_o <= {WIDTH{1'b0}};
        end else if (load_i) begin
            trial_r    <= {1'b1, {(WIDTH-1){1'b0}}};
            dac_code_o <= {1'b1, {(WIDTH-1){1'b0}}};
        end else if (step_i) begin
            trial_r    <= trial_r >> 1;
            dac_code_o <= (dac_code_o & ~trial_r)
                        | (comp_i ? trial_r : {WIDTH{1'b0}})
                        | (trial_r >> 1);
        end
    end

endmodule

// *** core/touch_adc_serial_sequencer.v ***
// Contract
// - Frame is three bytes, 24 shift clocks.
// - Acquire and enable panel drivers once channel known.
// - Three clocks later: convert, sample-and-hold holds.
// - Single-ended mode: drivers off at conversion start.
// - Convert over twelve clocks after acquisition.
// - Ratiometric: drivers stay on, thirteenth clock outputs.
// - Trailing clocks ignored, result output held low.
// - Channel 000: base-current diode bias to converter.
// - Channel 111: diode bias at 91x current.
// - Diode bias only during three acquisition clocks.
// - Channel 010: battery divider only while sampling.
// - Ignore command input until first high bit.
// - Command byte MSB first with fixed field order.
// - Resolution bit low 12-bit, high 8-bit.
// - Reference bit high single-ended, low ratiometric.
`timescale 1ns/1ps
`include "touch_adc_map.vh"

module touch_adc_serial_sequencer #(
    parameter RES_WIDTH = 12
) (
    // Clock and reset.
    input  wire                 core_clk_i,
    input  wire                 rst_i,
    // Serial link from the host.
    input  wire                 host_shift_clock_i,
    input  wire                 serial_cmd_i,
    output reg                  serial_result_o,
    // Converter analog control.
    input  wire                 comparator_i,
    output reg                  sample_track_o,
    output reg                  converting_o,
    output wire [RES_WIDTH-1:0] dac_code_o,
    // Panel drivers.
    output reg                  x_pos_drv_o,
    output reg                  x_neg_drv_o,
    output reg                  y_pos_drv_o,
    output reg                  y_neg_drv_o,
    // Diode bias and battery divider.
    output reg                  temp_bias_en_o,
    output reg                  temp_bias_91x_o,
    output reg                  batt_div_en_o,
    // Decoded command fields.
    output reg  [2:0]           channel_select_o,
    output reg                  ref_mode_select_o,
    output reg                  res_8bit_o,
    output reg  [1:0]           power_down_select_o
);

    // ------------------------------------------------------------------
    // States.
    // ------------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_CMD  = 2'h1;
    localparam ST_CONV = 2'h2;
    localparam ST_TAIL = 2'h3;

    reg [1:0] state_r;
    reg [4:0] cnt_r;
    reg [3:0] step_r;
    reg [7:0] shift_r;
    reg       prev_bit_r;
    reg       sar_load_r;
    reg       sar_step_r;
    reg [3:0] drv_sel;
    reg [3:0] nbits;
    reg [3:0] last_step;

    // ------------------------------------------------------------------
    // Input synchronisers and shift clock edge detection.
    // ------------------------------------------------------------------
    reg hclk_s1_r;
    reg hclk_s2_r;
    reg hclk_prev_r;
    reg din_s1_r;
    reg din_s2_r;
    reg comp_s1_r;
    reg comp_s2_r;

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            hclk_s1_r   <= 1'b0;
            hclk_s2_r   <= 1'b0;
            hclk_prev_r <= 1'b0;
            din_s1_r    <= 1'b0;
            din_s2_r    <= 1'b0;
            comp_s1_r   <= 1'b0;
            comp_s2_r   <= 1'b0;
        end else begin
            hclk_s1_r   <= host_shift_clock_i;
            hclk_s2_r   <= hclk_s1_r;
            hclk_prev_r <= hclk_s2_r;
            din_s1_r    <= serial_cmd_i;
            din_s2_r    <= din_s1_r;
            comp_s1_r   <= comparator_i;
            comp_s2_r   <= comp_s1_r;
        end
    end

    // The link clock is sampled like any pin, so its edges are seen about
    // three core cycles after they happen on the wire.
    wire rise = hclk_s2_r & ~hclk_prev_r;
    wire fall = ~hclk_s2_r & hclk_prev_r;

    // ------------------------------------------------------------------
    // Panel driver selection per channel.
    // ------------------------------------------------------------------
    always @* begin
        case (channel_select_o)
            `CH_Y_POS:  drv_sel = `DRV_Y_PAIR;
            `CH_Z1_POS: drv_sel = `DRV_YP_XN;
            `CH_Z2_POS: drv_sel = `DRV_YP_XN;
            `CH_X_POS:  drv_sel = `DRV_X_PAIR;
            default:    drv_sel = `DRV_NONE;
        endcase
    end

    // ------------------------------------------------------------------
    // Conversion length.
    // ------------------------------------------------------------------
    always @* begin
        nbits     = res_8bit_o ? `CONV_BITS_LO : `CONV_BITS_HI;
        last_step = ref_mode_select_o ? nbits
                                      : nbits + 4'h1;
    end

    // ------------------------------------------------------------------
    // Frame events, one core cycle wide.
    // ------------------------------------------------------------------
    // Acquisition opens at the fifth fall, once the channel bits are in,
    // and closes three host clocks later at the eighth fall.
    wire in_cmd     = (state_r == ST_CMD);
    wire start_seen = rise && (state_r == ST_IDLE) && din_s2_r;
    wire ch_done    = rise && in_cmd && (cnt_r == `CH_DONE_CNT);
    wire byte_done  = rise && in_cmd && (cnt_r == `BYTE_DONE_CNT);
    wire acq_start  = fall && in_cmd && (cnt_r == `ACQ_START_CNT);
    wire acq_end    = fall && in_cmd && (cnt_r == `ACQ_END_CNT);
    wire conv_last  = fall && (state_r == ST_CONV) &&
                      (step_r + 4'h1 == last_step);
    wire is_temp    = (channel_select_o == `CH_TEMP_BASE) ||
                      (channel_select_o == `CH_TEMP_91X);

    // ------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            state_r         <= ST_IDLE;
            cnt_r           <= 5'h00;
            step_r          <= 4'h0;
            shift_r         <= 8'h00;
            prev_bit_r      <= 1'b0;
            sar_load_r      <= 1'b0;
            sar_step_r      <= 1'b0;
            serial_result_o <= 1'b0;
            sample_track_o  <= 1'b0;
            converting_o    <= 1'b0;
        end else begin
            sar_load_r <= 1'b0;
            sar_step_r <= 1'b0;
            if (rise && state_r != ST_IDLE) begin
                cnt_r <= cnt_r + 5'h01;
            end
            case (state_r)
                ST_IDLE: begin
                    if (start_seen) begin
                        state_r <= ST_CMD;
                        cnt_r   <= 5'h01;
                        shift_r <= 8'h01;
                    end
                end
                ST_CMD: begin
                    if (rise) begin
                        shift_r <= {shift_r[6:0], din_s2_r};
                    end
                    if (acq_start) begin
                        sample_track_o <= 1'b1;
                    end
                    if (acq_end) begin
                        sample_track_o <= 1'b0;
                        converting_o   <= 1'b1;
                        sar_load_r     <= 1'b1;
                        step_r         <= 4'h0;
                        prev_bit_r     <= 1'b0;
                        state_r        <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // In ratiometric mode each bit leaves one fall after its
                    // decision, so an extra fall carries the last bit.
                    if (fall) begin
                        step_r <= step_r + 4'h1;
                        if (step_r < nbits) begin
                            sar_step_r <= 1'b1;
                            prev_bit_r <= comp_s2_r;
                            serial_result_o <= ref_mode_select_o
                                ? comp_s2_r : prev_bit_r;
                        end else begin
                            serial_result_o <= prev_bit_r;
                        end
                    end
                    if (conv_last) begin
                        state_r      <= ST_TAIL;
                        converting_o <= 1'b0;
                    end
                end
                ST_TAIL: begin
                    // The tail clocks count out the frame and hold the result line low.
                    if (fall) begin
                        serial_result_o <= 1'b0;
                        if (cnt_r == `FRAME_CLKS) begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Panel drivers.
    // ------------------------------------------------------------------
    // Single-ended conversions release the panel at hold; ratiometric
    // ones keep it driven until the last conversion step.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            x_pos_drv_o <= 1'b0;
            x_neg_drv_o <= 1'b0;
            y_pos_drv_o <= 1'b0;
            y_neg_drv_o <= 1'b0;
        end else if (acq_start) begin
            x_pos_drv_o <= drv_sel[3];
            x_neg_drv_o <= drv_sel[2];
            y_pos_drv_o <= drv_sel[1];
            y_neg_drv_o <= drv_sel[0];
        end else if ((acq_end && ref_mode_select_o) || conv_last) begin
            x_pos_drv_o <= 1'b0;
            x_neg_drv_o <= 1'b0;
            y_pos_drv_o <= 1'b0;
            y_neg_drv_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Command field capture.
    // ------------------------------------------------------------------
    // Fields stand until the next command byte overwrites them.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            channel_select_o    <= `RST_CHANNEL;
            ref_mode_select_o   <= 1'b0;
            res_8bit_o          <= 1'b0;
            power_down_select_o <= `RST_PD;
        end else begin
            if (ch_done) begin
                channel_select_o <= {shift_r[1:0], din_s2_r};
            end
            if (byte_done) begin
                res_8bit_o          <= shift_r[2];
                ref_mode_select_o   <= shift_r[1];
                power_down_select_o <= {shift_r[0], din_s2_r};
            end
        end
    end

    // ------------------------------------------------------------------
    // Diode bias and battery divider.
    // ------------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            temp_bias_en_o  <= 1'b0;
            temp_bias_91x_o <= 1'b0;
            batt_div_en_o   <= 1'b0;
        end else if (acq_start) begin
            temp_bias_en_o  <= is_temp;
            temp_bias_91x_o <= (channel_select_o == `CH_TEMP_91X);
            batt_div_en_o   <= (channel_select_o == `CH_BATTERY);
        end else if (acq_end) begin
            temp_bias_en_o  <= 1'b0;
            temp_bias_91x_o <= 1'b0;
            batt_div_en_o   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Successive approximation register.
    // ------------------------------------------------------------------
    // The SAR takes the stored decision, so the code it builds matches
    // the bits sent out on the result line.
    sar_register #(
        .WIDTH      (RES_WIDTH)
    ) u_sar (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .load_i     (sar_load_r),
        .step_i     (sar_step_r),
        .comp_i     (prev_bit_r),
        .dac_code_o (dac_code_o)
    );

endmodule

// *** tb/touch_adc_props.sv ***
`timescale 1ns/1ps
`include "touch_adc_map.vh"

// ----------------------------------------------------------------------
// Port timing checks for the serial sequencer.
// ----------------------------------------------------------------------
module touch_adc_props (
    // Clock and reset.
    input wire       core_clk_i,
    input wire       rst_i,
    // Converter and link outputs.
    input wire       serial_result_o,
    input wire       sample_track_o,
    input wire       converting_o,
    // Panel drivers.
    input wire       x_pos_drv_o,
    input wire       x_neg_drv_o,
    input wire       y_pos_drv_o,
    input wire       y_neg_drv_o,
    // Bias and divider.
    input wire       temp_bias_en_o,
    input wire       temp_bias_91x_o,
    input wire       batt_div_en_o,
    // Decoded fields.
    input wire [2:0] channel_select_o,
    input wire       ref_mode_select_o,
    input wire       res_8bit_o
);
    reg  [5:0] acq_cnt_r;
    reg  [7:0] conv_cnt_r;
    reg  [3:0] idle_cnt_r;
    wire [3:0] drv;
    assign drv = {x_pos_drv_o, x_neg_drv_o, y_pos_drv_o, y_neg_drv_o};

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Counts the length of acquisition, conversion and idle spans.
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            acq_cnt_r  <= 6'h00;
            conv_cnt_r <= 8'h00;
            idle_cnt_r <= 4'h0;
        end else begin
            acq_cnt_r  <= sample_track_o ? acq_cnt_r + 6'h01 : 6'h00;
            conv_cnt_r <= converting_o ? conv_cnt_r + 8'h01 : 8'h00;
            if (converting_o)
                idle_cnt_r <= 4'h0;
            else if (idle_cnt_r != 4'hf)
                idle_cnt_r <= idle_cnt_r + 4'h1;
        end
    end

    sequence s_acq_end;
        $fell(sample_track_o);
    endsequence
    property p_acq_len;
        s_acq_end |-> acq_cnt_r == 6'h18;
    endproperty
    a_acq_len: assert property (p_acq_len)
        else $error("acquisition span is not three host clocks");
    property p_hold;
        s_acq_end |-> converting_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("conversion did not follow acquisition");
    property p_bias_win;
        temp_bias_en_o |-> sample_track_o &&
            (channel_select_o == `CH_TEMP_BASE ||
             channel_select_o == `CH_TEMP_91X);
    endproperty
    a_bias_win: assert property (p_bias_win)
        else $error("diode bias outside a temperature acquisition");
    property p_bias_base;
        sample_track_o && channel_select_o == `CH_TEMP_BASE
            |-> temp_bias_en_o && !temp_bias_91x_o;
    endproperty
    a_bias_base: assert property (p_bias_base)
        else $error("base diode bias missing");
    property p_bias_91x;
        sample_track_o && channel_select_o == `CH_TEMP_91X
            |-> temp_bias_en_o && temp_bias_91x_o;
    endproperty
    a_bias_91x: assert property (p_bias_91x)
        else $error("high diode bias missing");
    property p_batt;
        batt_div_en_o == (sample_track_o &&
            channel_select_o == `CH_BATTERY);
    endproperty
    a_batt: assert property (p_batt)
        else $error("battery divider outside sampling");
    property p_se_off;
        converting_o && ref_mode_select_o |-> drv == `DRV_NONE;
    endproperty
    a_se_off: assert property (p_se_off)
        else $error("drivers on during single-ended conversion");
    property p_ratio_on;
        converting_o && !ref_mode_select_o &&
            channel_select_o == `CH_X_POS |-> drv == `DRV_X_PAIR;
    endproperty
    a_ratio_on: assert property (p_ratio_on)
        else $error("drivers off during ratiometric conversion");
    property p_conv_len;
        $fell(converting_o) |-> conv_cnt_r ==
            (res_8bit_o ? 8'h40 : 8'h60) +
            (ref_mode_select_o ? 8'h00 : 8'h08);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion step count wrong");
    property p_tail_low;
        idle_cnt_r > 4'h9 |-> !serial_result_o;
    endproperty
    a_tail_low: assert property (p_tail_low)
        else $error("result output not low after conversion");
endmodule

bind touch_adc_serial_sequencer touch_adc_props u_props (
    .core_clk_i       (core_clk_i),
    .rst_i            (rst_i),
    .serial_result_o  (serial_result_o),
    .sample_track_o   (sample_track_o),
    .converting_o     (converting_o),
    .x_pos_drv_o      (x_pos_drv_o),
    .x_neg_drv_o      (x_neg_drv_o),
    .y_pos_drv_o      (y_pos_drv_o),
    .y_neg_drv_o      (y_neg_drv_o),
    .temp_bias_en_o   (temp_bias_en_o),
    .temp_bias_91x_o  (temp_bias_91x_o),
    .batt_div_en_o    (batt_div_en_o),
    .channel_select_o (channel_select_o),
    .ref_mode_select_o(ref_mode_select_o),
    .res_8bit_o       (res_8bit_o)
);

// *** tb/host_port_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Host serial port; between frames its clock stands low or gives idle pulses with data low.
// ----------------------------------------------------------------------
module host_port_model (
    // Clock.
    input  wire        core_clk_i,
    // Serial link.
    output reg         host_shift_clock_i,
    output reg         serial_cmd_i,
    input  wire        serial_result_o,
    // Frame position.
    output reg  [5:0]  rise_cnt_o
);
    reg [23:0] rx_r;

    initial begin
        host_shift_clock_i = 1'b0;
        serial_cmd_i = 1'b0;
        rise_cnt_o = 6'h00;
        rx_r = 24'h000000;
    end

    // Sends idle clocks, then one frame; data changes while clock is low.
    task frame(input [7:0] cmd, input integer lead);
        integer k;
        begin
            for (k = 0; k < lead + 24; k = k + 1) begin
                @(posedge core_clk_i);
                if (k < lead)
                    serial_cmd_i <= 1'b0;
                else if (k - lead < 8)
                    serial_cmd_i <= cmd[7 - (k - lead)];
                else
                    serial_cmd_i <= 1'b1;
                if (k == 0)
                    rise_cnt_o <= 6'h00;
                repeat (3) @(posedge core_clk_i);
                host_shift_clock_i <= 1'b1;
                if (k >= lead) begin
                    rise_cnt_o <= rise_cnt_o + 6'h01;
                    rx_r <= {rx_r[22:0], serial_result_o};
                end
                repeat (4) @(posedge core_clk_i);
                host_shift_clock_i <= 1'b0;
            end
        end
    endtask
endmodule

// *** tb/tb_touch_adc_serial_sequencer.sv ***
`timescale 1ns/1ps
`include "touch_adc_map.vh"
`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end

module tb_touch_adc_serial_sequencer;
    reg         core_clk_i, rst_i, comparator_i;
    reg  [11:0] cur_code, code, base;
    reg  [7:0]  cmd;
    reg  [2:0]  ch;
    reg  [23:0] exp_rx;
    reg  [6:0]  acq_bits;
    reg  [3:0]  conv_drv;
    wire        hclk, cmd_bit, res_bit, strk, conv, x_p, x_n, y_p, y_n;
    wire        bias, b91, batt, refm, res8;
    wire [2:0]  chs;
    wire [11:0] dac;
    wire [1:0]  pds;
    wire [5:0]  rise_cnt;
    integer     i, cidx, bad_count, cmp_count;

    touch_adc_serial_sequencer DUT (
        .core_clk_i(core_clk_i), .rst_i(rst_i),
        .host_shift_clock_i(hclk), .serial_cmd_i(cmd_bit),
        .serial_result_o(res_bit), .comparator_i(comparator_i),
        .sample_track_o(strk), .converting_o(conv), .dac_code_o(dac),
        .x_pos_drv_o(x_p), .x_neg_drv_o(x_n),
        .y_pos_drv_o(y_p), .y_neg_drv_o(y_n),
        .temp_bias_en_o(bias), .temp_bias_91x_o(b91),
        .batt_div_en_o(batt), .channel_select_o(chs),
        .ref_mode_select_o(refm), .res_8bit_o(res8),
        .power_down_select_o(pds));
    host_port_model host (
        .core_clk_i(core_clk_i), .host_shift_clock_i(hclk),
        .serial_cmd_i(cmd_bit), .serial_result_o(res_bit),
        .rise_cnt_o(rise_cnt));

    function [3:0] drv_exp(input [2:0] c);
        case (c)
            `CH_Y_POS: drv_exp = `DRV_Y_PAIR;
            `CH_Z1_POS, `CH_Z2_POS: drv_exp = `DRV_YP_XN;
            `CH_X_POS: drv_exp = `DRV_X_PAIR;
            default: drv_exp = `DRV_NONE;
        endcase
    endfunction

    task finish_test;
        begin
            $display("compares %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    always #50 core_clk_i = ~core_clk_i;

    // Comparator gives the wanted code bit at each conversion step.
    always @(posedge core_clk_i) begin
        cidx = rise_cnt - 9;
        if (cidx >= 0 && cidx < 12)
            comparator_i <= cur_code[11 - cidx];
        else
            comparator_i <= ~comparator_i;
        if (strk === 1'b1)
            acq_bits <= {x_p, x_n, y_p, y_n, bias, b91, batt};
        if (conv === 1'b1)
            conv_drv <= {x_p, x_n, y_p, y_n};
    end

    initial begin
        repeat (8000) @(posedge core_clk_i);
        bad_count++;
        finish_test;
    end

    initial begin
        core_clk_i = 1'b0;
        rst_i = 1'b1;
        comparator_i = 1'b0;
        cur_code = 12'h000;
        bad_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        `CHECK({chs, res8, refm, pds, strk, conv, res_bit}, 10'h000)
        $display("test reset done");
        for (i = 0; i < 16; i = i + 1) begin
            ch = i[3:1];
            cmd = {1'b1, ch, i > 11, i[0], i[1:0]};
            code = 12'ha5c ^ (12'h111 * i[3:0]);
            cur_code <= code;
            host.frame(cmd, i % 3);
            base = cmd[3] ? {code[11:4], 4'h0} : code;
            exp_rx = {12'h000, base} << (cmd[2] ? 3 : 2);
            `CHECK(host.rx_r, exp_rx)
            `CHECK(cmd[3] ? {dac[11:4], 4'h0} : dac, base)
            `CHECK({chs, res8, refm, pds}, cmd[6:0])
            `CHECK(acq_bits, {drv_exp(ch), ch == 3'h0 || ch == 3'h7,
                ch == 3'h7, ch == 3'h2})
            `CHECK(conv_drv, cmd[2] ? 4'h0 : drv_exp(ch))
            $display("test %0d done", i);
        end
        finish_test;
    end
endmodule
